// file: logic/stc_cmd_if.sv
// interface carrying merged operator commands into the control core
`timescale 1ns/100ps
`default_nettype none
interface stc_cmd_if;
    logic audio_xfer_tgl;
    logic audio_src_tgl;
    logic rf_on;
    logic rf_off;
    logic mode_tgl;
    modport src (output audio_xfer_tgl, output audio_src_tgl, output rf_on, output rf_off, output mode_tgl);
    modport dst (input audio_xfer_tgl, input audio_src_tgl, input rf_on, input rf_off, input mode_tgl);
endinterface : stc_cmd_if
`default_nettype wire

// file: logic/stc_cmd_merge.sv
// merges local panel, console and remote command pulses
`timescale 1ns/100ps
`default_nettype none
module stc_cmd_merge (
    input  wire logic  local_only,
    input  wire logic  pnl_audio_xfer,
    input  wire logic  pnl_audio_src,
    input  wire logic  pnl_rf_on,
    input  wire logic  pnl_rf_off,
    input  wire logic  pnl_mode,
    input  wire logic  con_audio_xfer,
    input  wire logic  con_audio_src,
    input  wire logic  con_rf_on,
    input  wire logic  con_rf_off,
    input  wire logic  con_mode,
    input  wire logic  rem_audio_xfer,
    input  wire logic  rem_audio_src,
    input  wire logic  rem_rf_on,
    input  wire logic  rem_rf_off,
    input  wire logic  rem_mode,
    stc_cmd_if.src     cmd
);
    // ****************************************
    // local and remote sets
    // ****************************************
    // console accepted in both modes
    wire logic loc_xfer = pnl_audio_xfer | con_audio_xfer;
    wire logic loc_src  = pnl_audio_src  | con_audio_src;
    wire logic loc_on   = pnl_rf_on      | con_rf_on;
    wire logic loc_off  = pnl_rf_off     | con_rf_off;
    wire logic loc_mode = pnl_mode       | con_mode;
    wire logic rem_en   = ~local_only;
    wire logic rem_any_rf = rem_en & (rem_rf_on | rem_rf_off);

    // remote wins a conflict; a toggle pressed on both ends acts once
    // remote beats local
    assign cmd.audio_xfer_tgl = (rem_en & rem_audio_xfer) | loc_xfer;
    assign cmd.audio_src_tgl  = (rem_en & rem_audio_src) | loc_src;
    assign cmd.mode_tgl       = (rem_en & rem_mode) | loc_mode;
    assign cmd.rf_on  = rem_any_rf ? rem_rf_on  : loc_on & ~loc_off;
    assign cmd.rf_off = rem_any_rf ? rem_rf_off & ~rem_rf_on : loc_off;
endmodule : stc_cmd_merge
`default_nettype wire

// file: logic/stc_pkg.sv
// package of constants and types for the standby transfer control block
package stc_pkg;
    // ****************************************
    // lamp colour codes
    // ****************************************
    localparam int          LAMP_W        = 2;
    localparam logic [1:0]  LAMP_OFF      = 2'h0;
    localparam logic [1:0]  LAMP_GREEN    = 2'h1;
    localparam logic [1:0]  LAMP_AMBER    = 2'h2;
    localparam logic [1:0]  LAMP_RED      = 2'h3;

    // ****************************************
    // lamp index within a routing pair
    // ****************************************
    localparam int          IDX_LOAD      = 0;
    localparam int          IDX_ANT       = 1;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic        RST_AUDIO_AUTO = 1'b1;
    localparam logic        RST_AUDIO_BKP  = 1'b0;
    localparam logic        RST_MAINT      = 1'b0;

    // ****************************************
    // timing
    // ****************************************
    localparam int          CLK_MHZ       = 200;
    localparam int          BLINK_HALF_MS = 500;
    localparam int          BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;
    localparam int          BLINK_W       = 27;

    // ****************************************
    // rf control state
    // ****************************************
    typedef enum logic [1:0] {
        STC_RF_OFF   = 2'b00,
        STC_RF_ON    = 2'b01,
        STC_RF_MAINT = 2'b10
    } stc_rf_state_t;
endpackage : stc_pkg

// file: logic/stc_top.sv
// standby transfer control core: lamps, audio selection, rf enable
`timescale 1ns/100ps
`default_nettype none
module stc_top #(
    parameter int BLINK_HALF = stc_pkg::BLINK_HALF_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        local_only,
    input  wire logic        pnl_audio_xfer,
    input  wire logic        pnl_audio_src,
    input  wire logic        pnl_rf_on,
    input  wire logic        pnl_rf_off,
    input  wire logic        pnl_mode,
    input  wire logic        con_audio_xfer,
    input  wire logic        con_audio_src,
    input  wire logic        con_rf_on,
    input  wire logic        con_rf_off,
    input  wire logic        con_mode,
    input  wire logic        rem_audio_xfer,
    input  wire logic        rem_audio_src,
    input  wire logic        rem_rf_on,
    input  wire logic        rem_rf_off,
    input  wire logic        rem_mode,
    input  wire logic        tx_two_on_ant,
    input  wire logic        rf_xfer_manual,
    input  wire logic [1:0]  tx_fault_colour_one,
    input  wire logic [1:0]  tx_fault_colour_two,
    input  wire logic        tx_faulted_one,
    input  wire logic        tx_faulted_two,
    input  wire logic        tx_ready_one,
    input  wire logic        tx_ready_two,
    input  wire logic        sys_ilock_ok,
    input  wire logic        dummy_ilock_ok,
    input  wire logic        link_ok_one,
    input  wire logic        link_ok_two,
    input  wire logic        relay_ok,
    input  wire logic        main_fail,
    input  wire logic        main_low,
    input  wire logic        bkp_fail,
    input  wire logic        bkp_low,
    output logic [1:0]       lamp_one_ant,
    output logic [1:0]       lamp_one_load,
    output logic [1:0]       lamp_two_ant,
    output logic [1:0]       lamp_two_load,
    output logic             lamp_audio_auto,
    output logic             lamp_audio_manual,
    output logic             lamp_src_main,
    output logic             lamp_src_bkp,
    output logic             audio_use_bkp,
    output logic             lamp_rf_on,
    output logic             lamp_mode_maint,
    output logic             lamp_mode_normal,
    output logic             rf_en_one,
    output logic             rf_en_two
);
    // ****************************************
    // command merge
    // ****************************************
    stc_cmd_if cmd ();

    stc_cmd_merge u_merge (
        .local_only     (local_only),
        .pnl_audio_xfer (pnl_audio_xfer),
        .pnl_audio_src  (pnl_audio_src),
        .pnl_rf_on      (pnl_rf_on),
        .pnl_rf_off     (pnl_rf_off),
        .pnl_mode       (pnl_mode),
        .con_audio_xfer (con_audio_xfer),
        .con_audio_src  (con_audio_src),
        .con_rf_on      (con_rf_on),
        .con_rf_off     (con_rf_off),
        .con_mode       (con_mode),
        .rem_audio_xfer (rem_audio_xfer),
        .rem_audio_src  (rem_audio_src),
        .rem_rf_on      (rem_rf_on),
        .rem_rf_off     (rem_rf_off),
        .rem_mode       (rem_mode),
        .cmd            (cmd.src)
    );

    // ****************************************
    // audio selection
    // ****************************************
    logic audio_auto_r;
    logic audio_auto_nxt;
    logic audio_bkp_r;
    logic audio_bkp_nxt;

    wire logic main_bad = main_fail | main_low;
    wire logic bkp_bad  = bkp_fail  | bkp_low;

    // backup must be healthy to move
    wire logic auto_to_bkp  = ~audio_bkp_r & main_bad & ~bkp_bad;
    wire logic auto_to_main = audio_bkp_r & ~main_bad;

    // mode: source press forces manual, else the transfer button toggles
    // manual source selection forces manual
    assign audio_auto_nxt = cmd.audio_src_tgl ? 1'b0
                          : cmd.audio_xfer_tgl ? ~audio_auto_r
                          : audio_auto_r;

    // source: manual press wins, auto logic only while in auto
    // source button toggles
    assign audio_bkp_nxt = cmd.audio_src_tgl ? ~audio_bkp_r
                         : (audio_auto_r & auto_to_bkp) ? 1'b1
                         : (audio_auto_r & auto_to_main) ? 1'b0
                         : audio_bkp_r;

    // audio state registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            audio_auto_r <= stc_pkg::RST_AUDIO_AUTO;
            audio_bkp_r  <= stc_pkg::RST_AUDIO_BKP;
        end else if (ce) begin
            audio_auto_r <= audio_auto_nxt;
            audio_bkp_r  <= audio_bkp_nxt;
        end
    end

    // ****************************************
    // rf control
    // ****************************************
    stc_pkg::stc_rf_state_t rf_state_r;
    stc_pkg::stc_rf_state_t rf_state_nxt;
    logic                   maint_r;
    logic                   maint_nxt;

    // one transmitter on antenna, the other on test load
    wire logic ant_link_ok  = tx_two_on_ant ? link_ok_two : link_ok_one;
    wire logic rf_permit    = sys_ilock_ok & ant_link_ok & relay_ok;
    wire logic rf_is_on     = (rf_state_r != stc_pkg::STC_RF_OFF);

    // rf state machine
    always_comb begin
        rf_state_nxt = rf_state_r;
        case (rf_state_r)
            stc_pkg::STC_RF_OFF: begin
                if (cmd.rf_on && rf_permit)
                    rf_state_nxt = stc_pkg::STC_RF_ON;
            end
            stc_pkg::STC_RF_ON: begin
                if (cmd.rf_off || !rf_permit)
                    rf_state_nxt = stc_pkg::STC_RF_OFF;
                else if (maint_r && cmd.rf_on)
                    rf_state_nxt = stc_pkg::STC_RF_MAINT;
            end
            stc_pkg::STC_RF_MAINT: begin
                if (cmd.rf_off || !rf_permit)
                    rf_state_nxt = stc_pkg::STC_RF_OFF;
                else if (!maint_r)
                    rf_state_nxt = stc_pkg::STC_RF_ON;
            end
            default: rf_state_nxt = stc_pkg::STC_RF_OFF;
        endcase
        if (maint_r && cmd.rf_on && rf_permit && !cmd.rf_off)
            rf_state_nxt = stc_pkg::STC_RF_MAINT;
    end

    // mode toggles only under manual rf transfer; rf off forces normal
    // rf off forces normal mode
    assign maint_nxt = (rf_state_nxt == stc_pkg::STC_RF_OFF) ? 1'b0
                     : !rf_xfer_manual ? 1'b0
                     : cmd.mode_tgl ? ~maint_r
                     : maint_r;

    // rf state registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rf_state_r <= stc_pkg::STC_RF_OFF;
            maint_r    <= stc_pkg::RST_MAINT;
        end else if (ce) begin
            rf_state_r <= rf_state_nxt;
            maint_r    <= maint_nxt;
        end
    end

    // enables per role; transmitters themselves must be ready too
    wire logic ant_en_nxt  = (rf_state_nxt != stc_pkg::STC_RF_OFF);
    // maintenance itself enables the load side while rf is on
    // needs manual rf transfer and both interlocks intact
    wire logic load_en_nxt = ant_en_nxt & maint_nxt
                           & rf_xfer_manual & sys_ilock_ok & dummy_ilock_ok;
    wire logic en_one_nxt  = (tx_two_on_ant ? load_en_nxt : ant_en_nxt) & tx_ready_one;
    wire logic en_two_nxt  = (tx_two_on_ant ? ant_en_nxt : load_en_nxt) & tx_ready_two;

    // ****************************************
    // routing lamps
    // ****************************************
    logic [stc_pkg::BLINK_W-1:0] blink_cnt_r;
    logic                        blink_ph_r;
    wire logic                   blink_wrap = (blink_cnt_r == stc_pkg::BLINK_W'(BLINK_HALF - 1));

    // free-running blink phase; shared so all blinking lamps stay in step
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            blink_cnt_r <= '0;
            blink_ph_r  <= 1'b0;
        end else if (ce) begin
            blink_cnt_r <= blink_wrap ? '0 : blink_cnt_r + 1'b1;
            blink_ph_r  <= blink_wrap ? ~blink_ph_r : blink_ph_r;
        end
    end

    wire logic [1:0] col_one = tx_faulted_one ? tx_fault_colour_one : stc_pkg::LAMP_GREEN;
    wire logic [1:0] col_two = tx_faulted_two ? tx_fault_colour_two : stc_pkg::LAMP_GREEN;
    // blink load lamp while dummy interlock open
    wire logic       load_dark = ~dummy_ilock_ok & blink_ph_r;

    wire logic [1:0] one_ant_nxt  = tx_two_on_ant ? stc_pkg::LAMP_OFF : col_one;
    wire logic [1:0] one_load_nxt = (!tx_two_on_ant || load_dark) ? stc_pkg::LAMP_OFF : col_one;
    wire logic [1:0] two_ant_nxt  = tx_two_on_ant ? col_two : stc_pkg::LAMP_OFF;
    wire logic [1:0] two_load_nxt = (tx_two_on_ant || load_dark) ? stc_pkg::LAMP_OFF : col_two;

    // ****************************************
    // output registers
    // ****************************************
    // every output registered so lamps and enables are glitch free
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lamp_one_ant      <= stc_pkg::LAMP_OFF;
            lamp_one_load     <= stc_pkg::LAMP_OFF;
            lamp_two_ant      <= stc_pkg::LAMP_OFF;
            lamp_two_load     <= stc_pkg::LAMP_OFF;
            lamp_audio_auto   <= 1'b0;
            lamp_audio_manual <= 1'b0;
            lamp_src_main     <= 1'b0;
            lamp_src_bkp      <= 1'b0;
            audio_use_bkp     <= 1'b0;
            lamp_rf_on        <= 1'b0;
            lamp_mode_maint   <= 1'b0;
            lamp_mode_normal  <= 1'b0;
            rf_en_one         <= 1'b0;
            rf_en_two         <= 1'b0;
        end else if (ce) begin
            lamp_one_ant      <= one_ant_nxt;
            lamp_one_load     <= one_load_nxt;
            lamp_two_ant      <= two_ant_nxt;
            lamp_two_load     <= two_load_nxt;
            lamp_audio_auto   <= audio_auto_nxt;
            lamp_audio_manual <= ~audio_auto_nxt;
            lamp_src_main     <= ~audio_bkp_nxt;
            lamp_src_bkp      <= audio_bkp_nxt;
            audio_use_bkp     <= audio_bkp_nxt;
            lamp_rf_on        <= ant_en_nxt;
            lamp_mode_maint   <= maint_nxt;
            lamp_mode_normal  <= ~maint_nxt;
            rf_en_one         <= en_one_nxt;
            rf_en_two         <= en_two_nxt;
        end
    end
endmodule : stc_top
`default_nettype wire

// file: tb/stc_checker.sv
// concurrent checks on the ports of the standby transfer control block
`timescale 1ns/100ps
`default_nettype none
module stc_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic local_only,
    input wire logic pnl_audio_xfer,
    input wire logic pnl_audio_src,
    input wire logic pnl_rf_off,
    input wire logic con_audio_xfer,
    input wire logic con_audio_src,
    input wire logic rem_audio_xfer,
    input wire logic rem_audio_src,
    input wire logic rem_rf_on,
    input wire logic sys_ilock_ok,
    input wire logic relay_ok,
    input wire logic main_fail,
    input wire logic main_low,
    input wire logic bkp_fail,
    input wire logic bkp_low,
    input wire logic lamp_audio_auto,
    input wire logic lamp_audio_manual,
    input wire logic lamp_src_main,
    input wire logic lamp_src_bkp,
    input wire logic audio_use_bkp,
    input wire logic lamp_rf_on,
    input wire logic lamp_mode_maint,
    input wire logic lamp_mode_normal,
    input wire logic rf_en_one,
    input wire logic rf_en_two
);
    // ****************************************
    // assertions
    // ****************************************
    // any audio button, remote too, to stay conservative
    wire logic acmd = pnl_audio_xfer | pnl_audio_src | con_audio_xfer | con_audio_src | rem_audio_xfer | rem_audio_src;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_audio_onehot: assert property ($past(ce && !rst) |-> lamp_audio_auto ^ lamp_audio_manual)
        else $error("audio mode lamps not exclusive");
    a_src_onehot: assert property ($past(ce && !rst) |-> (lamp_src_main ^ lamp_src_bkp) && lamp_src_bkp == audio_use_bkp)
        else $error("source lamps disagree");
    a_rf_permit: assert property ($rose(lamp_rf_on) |-> $past(sys_ilock_ok && relay_ok))
        else $error("rf on without permissives");
    a_rf_off: assert property ($past(ce && !rst && pnl_rf_off && (local_only || !rem_rf_on))
        |-> !lamp_rf_on && !rf_en_one && !rf_en_two)
        else $error("rf off did not disable");
    a_off_normal: assert property (!lamp_rf_on && $past(ce && !rst) |-> lamp_mode_normal && !lamp_mode_maint)
        else $error("rf off left maintenance");
    a_auto_backup: assert property ($past(ce && !rst && lamp_audio_auto && !acmd && (main_fail || main_low)
        && !bkp_fail && !bkp_low) |-> audio_use_bkp)
        else $error("no transfer to backup");
    a_auto_return: assert property ($past(ce && !rst && lamp_audio_auto && !acmd && !main_fail && !main_low)
        |-> !audio_use_bkp)
        else $error("main not restored");
    a_backup_dead: assert property ($past(ce && !rst && lamp_audio_auto && !acmd && bkp_fail && !audio_use_bkp)
        |-> !audio_use_bkp)
        else $error("transfer to failed backup");
    a_manual_hold: assert property ($past(ce && !rst && lamp_audio_manual && !acmd) |-> $stable(audio_use_bkp))
        else $error("source moved in manual");
    a_src_manual: assert property ($past(ce && !rst && (pnl_audio_src || con_audio_src))
        |-> lamp_audio_manual && !lamp_audio_auto)
        else $error("source press kept auto");
    c_backup: cover property ($rose(audio_use_bkp));
    c_maint: cover property ($rose(lamp_mode_maint));
    c_two_on: cover property ($rose(rf_en_two));
endmodule : stc_checker
`default_nettype wire

// file: tb/stc_tx_model.sv
// behavioural model of the two transmitters facing the block
`timescale 1ns/100ps
`default_nettype none
module stc_tx_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] flt,
    input  wire logic       relay_bad,
    output logic            tx_ready_one,
    output logic            tx_ready_two,
    output logic            tx_faulted_one,
    output logic            tx_faulted_two,
    output logic [1:0]      tx_fault_colour_one,
    output logic [1:0]      tx_fault_colour_two,
    output logic            link_ok_one,
    output logic            link_ok_two,
    output logic            relay_ok
);
    // ****************************************
    // transmitter status
    // ****************************************
    // fixed colours so a wrong pair shows up
    assign tx_fault_colour_one = stc_pkg::LAMP_AMBER;
    assign tx_fault_colour_two = stc_pkg::LAMP_RED;
    assign relay_ok            = ~relay_bad;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_ready_one   <= 1'b0;
            tx_ready_two   <= 1'b0;
            tx_faulted_one <= 1'b0;
            tx_faulted_two <= 1'b0;
        end else begin
            tx_ready_one   <= 1'b1;
            tx_ready_two   <= 1'b1;
            tx_faulted_one <= flt[0];
            tx_faulted_two <= flt[1];
        end
    end
    // serial link follows readiness
    assign link_ok_one = tx_ready_one;
    assign link_ok_two = tx_ready_two;
endmodule : stc_tx_model
`default_nettype wire

// file: tb/tb.sv
// self-checking testbench for the standby transfer control block
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [14:0] XF = 15'h0001;
    localparam logic [14:0] SR = 15'h0002;
    localparam logic [14:0] ON = 15'h0004;
    localparam logic [14:0] OF = 15'h0008;
    localparam logic [14:0] MD = 15'h0010;
    localparam logic [3:0]  GG = {stc_pkg::LAMP_GREEN, stc_pkg::LAMP_GREEN};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        local_only = 1'b1;
    logic [14:0] cmd = 15'h0000;
    logic [1:0]  flt = 2'h0;
    logic        relay_bad = 1'b0;
    logic        tx_two_on_ant = 1'b0, rf_xfer_manual = 1'b0, sys_ilock_ok = 1'b1, dummy_ilock_ok = 1'b1;
    logic        main_fail = 1'b0, main_low = 1'b0, bkp_fail = 1'b0, bkp_low = 1'b0;
    logic        tx_ready_one, tx_ready_two, tx_faulted_one, tx_faulted_two, link_ok_one, link_ok_two, relay_ok;
    logic [1:0]  tx_fault_colour_one, tx_fault_colour_two, lamp_one_ant, lamp_one_load, lamp_two_ant, lamp_two_load;
    logic        lamp_audio_auto, lamp_audio_manual, lamp_src_main, lamp_src_bkp, audio_use_bkp;
    logic        lamp_rf_on, lamp_mode_maint, lamp_mode_normal, rf_en_one, rf_en_two;
    int          bad_count = 0;
    int          tests_run = 0;
    int          dark, lit, adark;
    // 200 MHz clock
    always #2.5 clk = ~clk;
    stc_tx_model model_u (.clk, .rst, .flt, .relay_bad, .tx_ready_one, .tx_ready_two, .tx_faulted_one, .tx_faulted_two,
        .tx_fault_colour_one, .tx_fault_colour_two, .link_ok_one, .link_ok_two, .relay_ok);
    // short blink so a full period fits a few cycles
    stc_top #(.BLINK_HALF(4)) dut_u (.clk, .rst, .ce, .local_only,
        .pnl_audio_xfer(cmd[0]), .pnl_audio_src(cmd[1]), .pnl_rf_on(cmd[2]), .pnl_rf_off(cmd[3]), .pnl_mode(cmd[4]),
        .con_audio_xfer(cmd[5]), .con_audio_src(cmd[6]), .con_rf_on(cmd[7]), .con_rf_off(cmd[8]), .con_mode(cmd[9]),
        .rem_audio_xfer(cmd[10]), .rem_audio_src(cmd[11]), .rem_rf_on(cmd[12]), .rem_rf_off(cmd[13]),
        .rem_mode(cmd[14]), .tx_two_on_ant, .rf_xfer_manual, .tx_fault_colour_one, .tx_fault_colour_two,
        .tx_faulted_one, .tx_faulted_two, .tx_ready_one, .tx_ready_two, .sys_ilock_ok, .dummy_ilock_ok,
        .link_ok_one, .link_ok_two, .relay_ok, .main_fail, .main_low, .bkp_fail, .bkp_low,
        .lamp_one_ant, .lamp_one_load, .lamp_two_ant, .lamp_two_load, .lamp_audio_auto, .lamp_audio_manual,
        .lamp_src_main, .lamp_src_bkp, .audio_use_bkp, .lamp_rf_on, .lamp_mode_maint, .lamp_mode_normal,
        .rf_en_one, .rf_en_two);
    // ****************************************
    // tasks
    // ****************************************
    // one-cycle command pulse, outputs settled on return
    task automatic press(input logic [14:0] m);
        cmd = m;
        @(negedge clk);
        cmd = 15'h0000;
        @(negedge clk);
    endtask : press
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    // watchdog, run needs about 90 cycles
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk({lamp_audio_auto, lamp_audio_manual, lamp_src_main, lamp_src_bkp}, 4'hA);
        chk({lamp_rf_on, lamp_mode_normal, rf_en_one, rf_en_two}, 4'h4);
        chk({lamp_one_ant, lamp_two_load}, GG);
        chk({lamp_one_load, lamp_two_ant}, 4'h0);
        flt = 2'h1;
        repeat (3) @(negedge clk);
        chk({2'h0, lamp_one_ant}, {2'h0, stc_pkg::LAMP_AMBER});
        flt = 2'h0;
        $display("lamp test done");
        main_low = 1'b1;
        repeat (2) @(negedge clk);
        chk({2'h0, audio_use_bkp, lamp_src_bkp}, 4'h3);
        main_low = 1'b0;
        repeat (2) @(negedge clk);
        chk({2'h0, audio_use_bkp, lamp_src_bkp}, 4'h0);
        main_fail = 1'b1;
        bkp_fail = 1'b1;
        repeat (2) @(negedge clk);
        chk({3'h0, audio_use_bkp}, 4'h0);
        press(XF);
        chk({2'h0, lamp_audio_auto, lamp_audio_manual}, 4'h1);
        // backup healthy only once manual, so auto would move now
        bkp_fail = 1'b0;
        repeat (2) @(negedge clk);
        chk({3'h0, audio_use_bkp}, 4'h0);
        press(SR << 5);
        main_fail = 1'b0;
        repeat (2) @(negedge clk);
        chk({2'h0, audio_use_bkp, lamp_src_main}, 4'h2);
        press(XF);
        @(negedge clk);
        chk({3'h0, audio_use_bkp}, 4'h0);
        press(SR);
        chk({1'b0, lamp_audio_auto, lamp_audio_manual, audio_use_bkp}, 4'h3);
        ce = 1'b0;
        press(XF);
        ce = 1'b1;
        chk({2'h0, lamp_audio_auto, lamp_audio_manual}, 4'h1);
        press(SR);
        $display("audio test done");
        sys_ilock_ok = 1'b0;
        press(ON);
        chk({1'b0, lamp_rf_on, rf_en_one, rf_en_two}, 4'h0);
        sys_ilock_ok = 1'b1;
        relay_bad = 1'b1;
        press(ON);
        chk({1'b0, lamp_rf_on, rf_en_one, rf_en_two}, 4'h0);
        relay_bad = 1'b0;
        press(ON);
        chk({1'b0, lamp_rf_on, rf_en_one, rf_en_two}, 4'h6);
        press(OF);
        chk({1'b0, lamp_rf_on, rf_en_one, rf_en_two}, 4'h0);
        rf_xfer_manual = 1'b1;
        press(ON);
        press(MD);
        chk({lamp_mode_maint, lamp_mode_normal, rf_en_one, rf_en_two}, 4'hB);
        press(ON);
        chk({lamp_mode_maint, lamp_mode_normal, rf_en_one, rf_en_two}, 4'hB);
        press(OF);
        chk({lamp_mode_maint, lamp_mode_normal, rf_en_one, rf_en_two}, 4'h4);
        press(MD);
        chk({lamp_mode_maint, lamp_mode_normal, rf_en_one, rf_en_two}, 4'h4);
        rf_xfer_manual = 1'b0;
        $display("rf test done");
        local_only = 1'b0;
        press(ON | (OF << 10));
        chk({3'h0, lamp_rf_on}, 4'h0);
        press(OF | (ON << 10));
        chk({3'h0, lamp_rf_on}, 4'h1);
        press(OF);
        local_only = 1'b1;
        press(ON << 10);
        chk({3'h0, lamp_rf_on}, 4'h0);
        press(ON << 5);
        chk({3'h0, lamp_rf_on}, 4'h1);
        press(OF << 5);
        chk({3'h0, lamp_rf_on}, 4'h0);
        $display("command source test done");
        tx_two_on_ant = 1'b1;
        repeat (2) @(negedge clk);
        chk({lamp_two_ant, lamp_one_load}, GG);
        press(ON);
        chk({2'h0, rf_en_one, rf_en_two}, 4'h1);
        press(OF);
        dummy_ilock_ok = 1'b0;
        dark = 0;
        lit = 0;
        adark = 0;
        // two and a half blink periods, antenna lamp must stay lit
        repeat (20) begin
            @(negedge clk);
            dark += int'(lamp_one_load === 2'h0);
            lit += int'(lamp_one_load === stc_pkg::LAMP_GREEN);
            adark += int'(lamp_two_ant === 2'h0);
        end
        chk({1'b0, adark > 0, dark > 0, lit > 0}, 4'h3);
        $display("routing test done");
        rst = 1'b1;
        @(negedge clk);
        chk({lamp_rf_on, lamp_audio_auto, lamp_src_main, lamp_mode_normal}, 4'h0);
        finish_test();
    end
endmodule : tb
bind stc_top stc_checker chk_u (.clk, .rst, .ce, .local_only, .pnl_audio_xfer, .pnl_audio_src, .pnl_rf_off,
    .con_audio_xfer, .con_audio_src, .rem_audio_xfer, .rem_audio_src, .rem_rf_on, .sys_ilock_ok, .relay_ok,
    .main_fail, .main_low, .bkp_fail, .bkp_low, .lamp_audio_auto, .lamp_audio_manual, .lamp_src_main,
    .lamp_src_bkp, .audio_use_bkp, .lamp_rf_on, .lamp_mode_maint, .lamp_mode_normal, .rf_en_one, .rf_en_two);
`default_nettype wire
